// ===== pkg/nvm_access_map.svh
// Command codes, area bounds and reset values for the store access handler.
`ifndef NVM_ACCESS_MAP_SVH
`define NVM_ACCESS_MAP_SVH

// Command codes carried in the command phase of a general call.
`define CMD_LOAD_ADDR 8'h10
`define CMD_WRITE_BYTE 8'h12
`define CMD_READ_BYTE 8'h14

// Store areas by word address, inclusive bounds.
`define USER2_LO 15'h0080
`define USER2_HI 15'h03ff
`define CFG_UP_LO 15'h0050
`define CFG_UP_HI 15'h007e
`define RSVD_LO 15'h0040
`define RSVD_HI 15'h004e
`define USER1_LO 15'h0012
`define USER1_HI 15'h003e
`define CFG_LOW_LO 15'h0000
`define CFG_LOW_HI 15'h0010

// Reset values.
`define ADDR_RESET 16'h0000
`define BYTE_RESET 8'h00

`endif

// ===== pkg/nvm_access_pkg.sv
// Types shared by the store access handler.
package nvm_access_pkg;

	// Transaction states, Gray coded along idle, command, address, data.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ADDR_HI = 3'b011,
		ST_ADDR_LO = 3'b010,
		ST_WDATA = 3'b110,
		ST_RDATA = 3'b111,
		ST_DISCARD = 3'b101
	} state_e;

	// Area classes of the nonvolatile store.
	typedef enum logic [2:0] {
		AREA_USER,
		AREA_CFG,
		AREA_RSVD,
		AREA_GAP
	} area_e;

endpackage : nvm_access_pkg

// ===== hdl/nvm_access.sv
// General-call command handler for access to the nonvolatile store.
`timescale 1ns/10ps
`default_nettype none
`include "nvm_access_map.svh"

module nvm_access
	import nvm_access_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sum_ok,
	input wire logic gc_start,
	input wire logic gc_stop,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rd_req,
	input wire logic nvm_busy,
	input wire logic nvm_rvalid,
	input wire logic [7:0] nvm_rdata,
	output logic link_enable,
	output logic ack_valid,
	output logic ack,
	output logic tx_valid,
	output logic tx_ack,
	output logic [7:0] tx_data,
	output logic nvm_req,
	output logic nvm_we,
	output logic [15:0] nvm_addr,
	output logic [7:0] nvm_wdata
);

	// ==========================================================
	// Area decode
	// Byte address to word address, then into an area class.
	function automatic area_e classify(input logic [15:0] byte_addr);
		logic [14:0] w;
		w = byte_addr[15:1];
		if (w >= `USER2_LO && w <= `USER2_HI)
			classify = AREA_USER;
		else if (w >= `CFG_UP_LO && w <= `CFG_UP_HI)
			classify = AREA_CFG;
		else if (w >= `RSVD_LO && w <= `RSVD_HI)
			classify = AREA_RSVD;
		else if (w >= `USER1_LO && w <= `USER1_HI)
			classify = AREA_USER;
		else if (w <= `CFG_LOW_HI)
			classify = AREA_CFG;
		else
			classify = AREA_GAP;
	endfunction : classify

	// ==========================================================
	// State
	state_e state, next_state;
	logic sampled, next_sampled;
	logic next_link_enable;
	logic next_ack_valid, next_ack;
	logic next_tx_valid, next_tx_ack;
	logic [7:0] next_tx_data;
	logic next_nvm_req, next_nvm_we;
	logic [15:0] next_nvm_addr;
	logic [7:0] next_nvm_wdata;
	logic [7:0] addr_hi, next_addr_hi;
	logic hi_ok, next_hi_ok;
	logic rd_wait, next_rd_wait;
	logic rd_ready, next_rd_ready;
	logic [7:0] rd_buf, next_rd_buf;
	logic busy;

	// The request flop and an outstanding read count as busy, so a byte
	// arriving right behind an accepted access is never let through.
	assign busy = nvm_busy | nvm_req | rd_wait;

	// Next-value logic for the whole handler.
	always_comb begin
		next_state = state;
		next_sampled = 1'b1;
		next_link_enable = link_enable;
		next_ack_valid = 1'b0;
		next_ack = ack;
		next_tx_valid = 1'b0;
		next_tx_ack = tx_ack;
		next_tx_data = tx_data;
		next_nvm_req = 1'b0;
		next_nvm_we = nvm_we;
		next_nvm_addr = nvm_addr;
		next_nvm_wdata = nvm_wdata;
		next_addr_hi = addr_hi;
		next_hi_ok = hi_ok;
		next_rd_wait = rd_wait;
		next_rd_ready = rd_ready;
		next_rd_buf = rd_buf;
		if (!sampled)
			next_link_enable = sum_ok;
		// Read completion from the store.
		if (nvm_rvalid) begin
			next_rd_wait = 1'b0;
			next_rd_ready = 1'b1;
			next_rd_buf = nvm_rdata;
		end
		if (gc_start && link_enable)
			next_state = ST_CMD;
		else if (gc_stop)
			next_state = ST_IDLE;
		else if (rx_valid && state != ST_IDLE) begin
			next_ack_valid = 1'b1;
			next_ack = link_enable & ~busy;
			next_state = ST_DISCARD;
			case (state)
				ST_CMD: begin
					case (rx_data)
						`CMD_LOAD_ADDR: next_state = ST_ADDR_HI;
						`CMD_WRITE_BYTE: next_state = ST_WDATA;
						`CMD_READ_BYTE: begin
							next_state = ST_RDATA;
							// Drop stale data; a byte landing now wins.
							next_rd_ready = nvm_rvalid;
							if (link_enable && !busy) begin
								next_nvm_req = 1'b1;
								next_nvm_we = 1'b0;
								next_rd_wait = 1'b1;
							end
						end
						default: next_ack = 1'b0;
					endcase
					next_hi_ok = next_ack;
				end
				ST_ADDR_HI: begin
					next_addr_hi = rx_data;
					next_hi_ok = hi_ok & next_ack;
					next_state = ST_ADDR_LO;
				end
				ST_ADDR_LO: begin
					if (hi_ok && next_ack)
						next_nvm_addr = {addr_hi, rx_data};
				end
				ST_WDATA: begin
					if (hi_ok && next_ack &&
					    classify(nvm_addr) != AREA_RSVD) begin
						next_nvm_req = 1'b1;
						next_nvm_we = 1'b1;
						next_nvm_wdata = rx_data;
					end
					next_ack = hi_ok & next_ack;
				end
				// A second data byte or a stray write is refused.
				default: next_ack = 1'b0;
			endcase
		end else if (rd_req && state == ST_RDATA) begin
			next_tx_valid = 1'b1;
			next_tx_ack = link_enable & rd_ready;
			next_tx_data = rd_buf;
		end
	end

	// Registers; all outputs come straight from these flops.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			sampled <= 1'b0;
			link_enable <= 1'b0;
			ack_valid <= 1'b0;
			ack <= 1'b0;
			tx_valid <= 1'b0;
			tx_ack <= 1'b0;
			tx_data <= `BYTE_RESET;
			nvm_req <= 1'b0;
			nvm_we <= 1'b0;
			nvm_addr <= `ADDR_RESET;
			nvm_wdata <= `BYTE_RESET;
			addr_hi <= `BYTE_RESET;
			hi_ok <= 1'b0;
			rd_wait <= 1'b0;
			rd_ready <= 1'b0;
			rd_buf <= `BYTE_RESET;
		end else begin
			state <= next_state;
			sampled <= next_sampled;
			link_enable <= next_link_enable;
			ack_valid <= next_ack_valid;
			ack <= next_ack;
			tx_valid <= next_tx_valid;
			tx_ack <= next_tx_ack;
			tx_data <= next_tx_data;
			nvm_req <= next_nvm_req;
			nvm_we <= next_nvm_we;
			nvm_addr <= next_nvm_addr;
			nvm_wdata <= next_nvm_wdata;
			addr_hi <= next_addr_hi;
			hi_ok <= next_hi_ok;
			rd_wait <= next_rd_wait;
			rd_ready <= next_rd_ready;
			rd_buf <= next_rd_buf;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_busy_nack: assert property (
		rx_valid && state != ST_IDLE && !gc_start && !gc_stop && busy
		|=> ack_valid && !ack)
		else $error("busy store byte was acknowledged");

	a_link_refuse: assert property (
		!link_enable && sampled |-> ##1 !ack && !tx_ack && !nvm_req)
		else $error("disabled link answered or accessed store");

	a_addr_idle: assert property (
		$changed(nvm_addr) |-> $past(rx_valid && state == ST_ADDR_LO
		&& !busy && link_enable))
		else $error("held address changed outside idle load");

	a_addr_order: assert property (
		$changed(nvm_addr) |-> nvm_addr[15:8] == $past(addr_hi))
		else $error("address high byte not first byte");

	a_rsvd_block: assert property (
		nvm_req && nvm_we |-> classify(nvm_addr) != AREA_RSVD)
		else $error("write issued to reserved area");

	a_write_ack: assert property (
		nvm_req && nvm_we |-> ack_valid && ack && $past(hi_ok))
		else $error("store write without both phases acked");

	a_write_data: assert property (
		rx_valid && state == ST_WDATA && !gc_start && !gc_stop && hi_ok
		&& !busy && link_enable && classify(nvm_addr) == AREA_USER
		|=> nvm_req && nvm_we && nvm_wdata == $past(rx_data))
		else $error("user write not programmed");

	a_read_start: assert property (
		rx_valid && state == ST_CMD && rx_data == `CMD_READ_BYTE
		&& !gc_start && !gc_stop && !busy && link_enable
		|=> nvm_req && !nvm_we && ack ##1 rd_wait)
		else $error("read command did not start store read");

	a_read_data: assert property (
		rd_req && state == ST_RDATA && rd_ready && link_enable
		&& !rx_valid && !gc_start && !gc_stop
		|=> tx_valid && tx_ack && tx_data == $past(rd_buf))
		else $error("read data not returned with ack");

	c_load: cover property (state == ST_ADDR_LO && rx_valid && !busy);
	c_write: cover property (nvm_req && nvm_we);
	c_read_ok: cover property (tx_valid && tx_ack);
	c_read_nack: cover property (tx_valid && !tx_ack);

endmodule : nvm_access
`default_nettype wire

// ===== dv/nvm_store_model.sv
// Behavioural model of the nonvolatile store macro behind the handler.
`timescale 1ns/10ps
`default_nettype none
module nvm_store_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] lat,
	input wire logic nvm_req,
	input wire logic nvm_we,
	input wire logic [15:0] nvm_addr,
	input wire logic [7:0] nvm_wdata,
	output logic nvm_busy,
	output logic nvm_rvalid,
	output logic [7:0] nvm_rdata
);
	logic [7:0] mem [0:2047];
	logic [5:0] cnt;
	logic rd;
	logic [10:0] a;
	// ====
	// Store contents
	// Known pattern, so the bench can predict unwritten bytes.
	initial begin
		for (int i = 0; i < 2048; i++)
			mem[i] = i[7:0] ^ 8'ha5;
	end
	// Busy rises on the edge after a request and lasts 4*lat+1 cycles.
	// Read data toggles when not valid, so a stale byte never matches.
	// store access
	always @(posedge clk or posedge rst) begin
		nvm_rvalid <= 1'b0;
		nvm_rdata <= ~nvm_rdata;
		if (rst) begin
			nvm_busy <= 1'b0;
			nvm_rdata <= 8'h5a;
		end else if (nvm_req) begin
			nvm_busy <= 1'b1;
			cnt <= {lat, 2'b00};
			rd <= !nvm_we;
			a <= nvm_addr[10:0];
			if (nvm_we)
				mem[nvm_addr[10:0]] <= nvm_wdata;
		end else if (nvm_busy && cnt != 6'h0)
			cnt <= cnt - 6'h1;
		else if (nvm_busy) begin
			nvm_busy <= 1'b0;
			nvm_rvalid <= rd;
			nvm_rdata <= mem[a];
		end
	end
endmodule : nvm_store_model
`default_nettype wire

// ===== dv/nvm_access_tb_top.sv
// Self-checking bench for the store access command handler.
`timescale 1ns/10ps
`default_nettype none
`include "nvm_access_map.svh"
module nvm_access_tb_top;
	logic clk, rst, sum_ok, gc_start, gc_stop, rx_valid, rd_req, seen, lk;
	logic nvm_busy, nvm_rvalid, link_enable, ack_valid, ack, tx_valid;
	logic tx_ack, nvm_req, nvm_we;
	logic [7:0] rx_data, nvm_rdata, tx_data, nvm_wdata, d;
	logic [15:0] nvm_addr, a;
	logic [3:0] lat;
	logic [7:0] ref_mem [0:2047];
	logic [15:0] corner [6] = '{16'h0080, 16'h009d, 16'h009e, 16'h007f,
		16'h07ff, 16'h0000};
	int fails, cmp_count, i, n;
	nvm_access dut (.clk, .rst, .sum_ok, .gc_start, .gc_stop, .rx_valid,
		.rx_data, .rd_req, .nvm_busy, .nvm_rvalid, .nvm_rdata, .link_enable,
		.ack_valid, .ack, .tx_valid, .tx_ack, .tx_data, .nvm_req, .nvm_we,
		.nvm_addr, .nvm_wdata);
	nvm_store_model store (.clk, .rst, .lat, .nvm_req, .nvm_we, .nvm_addr,
		.nvm_wdata, .nvm_busy, .nvm_rvalid, .nvm_rdata);
	// ====
	// Helpers
	function automatic logic rsvd(input logic [15:0] x);
		return x[15:1] >= `RSVD_LO && x[15:1] <= `RSVD_HI;
	endfunction : rsvd
	task automatic chk(input string s, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic wrap_up;
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// Bounded wait: sel 0 for an idle store, 1 for returned read data.
	task automatic wt(input logic sel);
		n = 0;
		while ((sel ? !nvm_rvalid : nvm_busy) && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n == 300) begin
			fails++;
			wrap_up();
		end
	endtask : wt
	task automatic gc(input logic s);
		@(negedge clk);
		gc_start = s;
		gc_stop = !s;
		@(negedge clk);
		gc_start = 1'b0;
		gc_stop = 1'b0;
	endtask : gc
	task automatic put(input logic [7:0] b, input logic e);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_data = b;
		@(negedge clk);
		rx_valid = 1'b0;
		seen = nvm_req;
		chk("ack", 16'({e, lk}), 16'({ack, ack_valid}));
	endtask : put
	task automatic pull(input logic ok, input logic [7:0] x);
		@(negedge clk);
		rd_req = 1'b1;
		@(negedge clk);
		rd_req = 1'b0;
		chk("tx", 16'({1'b1, ok, ok ? x : 8'h00}),
			16'({tx_valid, tx_ack, ok ? tx_data : 8'h00}));
	endtask : pull
	task automatic load(input logic [15:0] x, input logic e);
		gc(1'b1);
		put(`CMD_LOAD_ADDR, e);
		put(x[15:8], e);
		put(x[7:0], e);
		gc(1'b0);
	endtask : load
	task automatic wr(input logic [7:0] x, input logic e, input logic q);
		gc(1'b1);
		put(`CMD_WRITE_BYTE, e);
		put(x, e);
		chk("nvm_req", 16'(q), 16'(seen));
		if (q)
			chk("wr", {8'h1, x}, {7'h0, nvm_we, nvm_wdata});
		if (q)
			ref_mem[a[10:0]] = x;
		gc(1'b0);
	endtask : wr
	task automatic rd(input logic [7:0] x);
		gc(1'b1);
		put(`CMD_READ_BYTE, 1'b1);
		wt(1'b1);
		pull(1'b1, x);
		gc(1'b0);
	endtask : rd
	task automatic do_reset(input logic ok);
		@(negedge clk);
		rst = 1'b1;
		sum_ok = ok;
		// A refused link takes no byte at all, so no ack strobe either.
		lk = ok;
		a = `ADDR_RESET;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk("link", 16'(ok), 16'(link_enable));
		chk("nvm_addr", `ADDR_RESET, nvm_addr);
	endtask : do_reset
	// ====
	// Clock and main sequence
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rst, sum_ok, gc_start, gc_stop, rx_valid, rd_req, seen} = 7'h40;
		rx_data = 8'h00;
		lat = 4'h0;
		fails = 0;
		cmp_count = 0;
		void'($urandom(32'hd0ec5c47));
		for (i = 0; i < 2048; i++)
			ref_mem[i] = i[7:0] ^ 8'ha5;
		do_reset(1'b0);
		load(16'h0123, 1'b0);
		chk("nvm_addr", `ADDR_RESET, nvm_addr);
		do_reset(1'b1);
		// Area corners first, then random addresses, each read back twice.
		for (i = 0; i < 40; i++) begin
			a = (i < 6) ? corner[i] : 16'($urandom_range(0, 2047));
			lat = 4'($urandom_range(0, 5));
			d = 8'($urandom);
			load(a, 1'b1);
			chk("nvm_addr", a, nvm_addr);
			wr(d, 1'b1, !rsvd(a));
			wt(1'b0);
			rd(ref_mem[a[10:0]]);
			rd(ref_mem[a[10:0]]);
		end
		// Busy store: address and write refused, old address kept.
		lat = 4'hf;
		a = 16'h0300;
		load(a, 1'b1);
		wr(8'h3c, 1'b1, 1'b1);
		load(16'h0301, 1'b0);
		chk("nvm_addr", 16'h0300, nvm_addr);
		wr(8'hc3, 1'b0, 1'b0);
		// A read refused while busy must not hand out older data.
		gc(1'b1);
		put(`CMD_READ_BYTE, 1'b0);
		pull(1'b0, 8'h00);
		gc(1'b0);
		wt(1'b0);
		// Data asked for too early, then the whole read retried.
		lat = 4'h4;
		gc(1'b1);
		put(`CMD_READ_BYTE, 1'b1);
		pull(1'b0, 8'h00);
		gc(1'b0);
		wt(1'b0);
		rd(8'h3c);
		// Unknown code and a surplus address byte are refused.
		gc(1'b1);
		put(8'h16, 1'b0);
		gc(1'b0);
		gc(1'b1);
		put(`CMD_LOAD_ADDR, 1'b1);
		put(8'h00, 1'b1);
		put(8'h42, 1'b1);
		put(8'h77, 1'b0);
		gc(1'b0);
		chk("nvm_addr", 16'h0042, nvm_addr);
		// Checksum is taken as rewritten before this reset.
		do_reset(1'b1);
		wrap_up();
	end
endmodule : nvm_access_tb_top
`default_nettype wire
